// ==== design/iasr_pkg.sv ====
// Shared constants and types of the integrating converter sequencer and readout
package iasr_pkg;

	localparam int CLK_PERIOD_NS = 100;

	// Internally timed phases of one measure cycle, in ns, and their cycle counts
	localparam int ADCONV_NS = 135600;
	localparam int ADRST_NS  = 3200;
	localparam int IRST_NS   = 36000;
	localparam int ADCONV_CYC_I = (ADCONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADRST_CYC_I  = (ADRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IRST_CYC_I   = (IRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int         CNT_W        = 11;
	localparam logic [10:0] ADCONV_CYC  = ADCONV_CYC_I[10:0];
	localparam logic [10:0] ADC_END_CYC = 11'(ADCONV_CYC_I + ADRST_CYC_I);
	localparam logic [10:0] IRST_CYC    = IRST_CYC_I[10:0];

	// Measure cycle and data-ready delay in system clock periods
	localparam logic [10:0] MRAZ_LP_CYC = 11'h610;
	localparam logic [10:0] MRAZ_HS_CYC = 11'h64C;
	localparam logic [10:0] CMDR_CYC    = 11'h566;

	localparam logic [1:0] SYNC_FILL = 2'h2;
	localparam logic [1:0] INIT_DONE = 2'h3;

	localparam int NUM_CH      = 32;
	localparam int WIDE_BITS   = 20;
	localparam int NARROW_BITS = 16;
	localparam int TRUNC_BITS  = 4;
	localparam int SR_WIDE     = NUM_CH * WIDE_BITS;
	localparam int SR_NARROW   = NUM_CH * NARROW_BITS;
	localparam int ANALOG_BITS = 22;

	localparam logic [19:0] ZERO_CODE = 20'h01000;
	localparam logic [19:0] FULL_CODE = 20'hFFFFF;

	typedef enum logic [2:0] {
		ST1_NC_MEAS_HI,
		ST2_PREP_A,
		ST3_INT_A,
		ST4_INT_B_MEAS_A,
		ST5_INT_A_MEAS_B,
		ST6_INT_B,
		ST7_PREP_B,
		ST8_NC_MEAS_LO
	} iasr_state_type;

	typedef enum logic [1:0] {
		PH_CONVERT,
		PH_ADC_RESET,
		PH_INT_RESET
	} iasr_phase_type;

	typedef struct packed {
		logic           meas_active;
		logic           meas_side_b;
		iasr_phase_type phase;
		logic           integ_a;
		logic           integ_b;
		logic           grounded;
	} iasr_status_type;

	typedef logic signed [ANALOG_BITS-1:0]            iasr_analog_type;
	typedef logic [NUM_CH-1:0][ANALOG_BITS-1:0]       iasr_analog_bus_type;
	typedef logic [NUM_CH-1:0][WIDE_BITS-1:0]         iasr_words_type;

endpackage

// ==== design/iasr_serial_out.sv ====
// Output shift register with parallel load and daisy-chain fill
`timescale 1ns/1ps
module iasr_serial_out (
	input  wire logic                 core_clk_in,
	input  wire logic                 nrst_in,
	input  wire logic                 load_in,
	input  wire logic                 wide_in,
	input  wire iasr_pkg::iasr_words_type words_in,
	input  wire logic                 shift_in,
	input  wire logic                 chain_in,
	output logic                      serial_out
);
	import iasr_pkg::*;

	logic [SR_WIDE-1:0] sr_q, sr_d;
	logic [SR_WIDE-1:0] load_wide;
	logic [SR_WIDE-1:0] load_narrow;
	logic               wide_q, wide_d;
	logic               ser_q, ser_d;

	// Channel 0 sits at the top so it leaves first
	generate
		for (genvar i = 0; i < NUM_CH; i++) begin : g_pack
			assign load_wide[SR_WIDE-1-WIDE_BITS*i -: WIDE_BITS] = words_in[i];
			assign load_narrow[SR_NARROW-1-NARROW_BITS*i -: NARROW_BITS] = words_in[i][WIDE_BITS-1:TRUNC_BITS];
		end
	endgenerate
	assign load_narrow[SR_WIDE-1:SR_NARROW] = '0;

	always_comb begin
		sr_d   = sr_q;
		wide_d = wide_q;
		if (load_in) begin
			wide_d = wide_in;
			sr_d   = wide_in ? load_wide : load_narrow;
		end else if (shift_in) begin
			sr_d = {sr_q[SR_WIDE-2:0], chain_in};
		end
		// Tap moves down in narrow mode so chain bits follow with no gap
		ser_d = wide_d ? sr_d[SR_WIDE-1] : sr_d[SR_NARROW-1];
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			sr_q   <= '0;
			wide_q <= 1'b1;
			ser_q  <= 1'b0;
		end else begin
			sr_q   <= sr_d;
			wide_q <= wide_d;
			ser_q  <= ser_d;
		end
	end

	assign serial_out = ser_q;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);

	chk_narrow_trunc: assert property (load_in && !wide_in |=>
		sr_q[SR_NARROW-1 -: NARROW_BITS] == $past(words_in[0][WIDE_BITS-1:TRUNC_BITS]) && !wide_q)
		else $error("narrow load does not drop the low bits");
	chk_chain_fill: assert property (shift_in && !load_in |=> sr_q[0] == $past(chain_in))
		else $error("chain bit not taken on shift");
	chk_bit_advance: assert property (shift_in && !load_in && wide_q |=> serial_out == $past(sr_q[SR_WIDE-2]))
		else $error("serial output did not advance");
	cov_narrow_load: cover property (load_in && !wide_in);

endmodule // iasr_serial_out

// ==== design/iasr_sequencer.sv ====
// Integrate/measure sequencer, data-ready handshake and serial readout
`timescale 1ns/1ps
// Contract
// - Start non-continuous: state 8 with select low, state 1 with select high.
// - After two states, continuous mode alternates states 4 and 5 per select change.
// - Continuous mode: data-ready falls a fixed delay after each select change.
// - Phases take 135.6 us convert, 3.2 us converter reset, 36 us integrator reset; integrator reset here is the rest of the cycle, 16.4 or 22.4 us.
// - Early integration end enters states 8/7 or 1/2, inputs grounded, resume in 6 or 3.
// - Long enough integration returns to continuous; first one in state 3 may be short.
// - Width select 1 gives 20-bit words, 0 drops four low bits.
// - Zero maps to offset code, saturate to all ones and all zeros.
// - Latest result ready at data-ready fall, bits advance on shift clock falls.
// - Data-ready falls in step with a falling system clock edge.
// - Data-ready returns high on a falling shift clock edge.
// - Chain input sampled at shift clock falls and shifted through.
// - State advances on select level and internal measure-busy level.
// - Measure cycle 1552 or 1612 periods, data-ready at 1382.
// - Preparation states keep integrations alternating between sides A and B.
// - Data-ready stays low until shift clock goes high then low.
module iasr_sequencer (
	input  wire logic                          core_clk_in,
	input  wire logic                          nrst_in,
	input  wire logic                          integrate_select_in,
	input  wire logic                          shift_clock_in,
	input  wire logic                          chain_in,
	input  wire logic                          word_width_select_in,
	input  wire logic                          high_speed_in,
	input  wire iasr_pkg::iasr_analog_bus_type adc_value_in,
	output logic                               data_ready_n_out,
	output logic                               serial_out,
	output iasr_pkg::iasr_status_type          status_out
);
	import iasr_pkg::*;

	// Pin synchronisers: select, shift clock, chain, width, speed
	logic [4:0] pin_s1_q;
	logic [4:0] pin_s2_q;
	logic       sck_prev_q;
	logic       sel;
	logic       sck_fall;

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			pin_s1_q   <= 5'h00;
			pin_s2_q   <= 5'h00;
			sck_prev_q <= 1'b0;
		end else begin
			pin_s1_q   <= {high_speed_in, word_width_select_in, chain_in, shift_clock_in, integrate_select_in};
			pin_s2_q   <= pin_s1_q;
			sck_prev_q <= pin_s2_q[1];
		end
	end

	assign sel      = pin_s2_q[0];
	assign sck_fall = sck_prev_q && !pin_s2_q[1];

	// Sequencer state
	iasr_state_type   state_q, state_d;
	logic [1:0]       init_q, init_d;
	logic             meas_q, meas_d;
	logic             side_b_q, side_b_d;
	logic             pend_q, pend_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] meas_len;
	logic             meas_end;
	logic             ready_pulse;

	assign meas_len    = pin_s2_q[4] ? MRAZ_HS_CYC : MRAZ_LP_CYC;
	assign meas_end    = meas_q && (cnt_q == meas_len - 11'h001);
	assign ready_pulse = meas_q && (cnt_q == CMDR_CYC - 11'h001);

	always_comb begin
		state_d  = state_q;
		init_d   = init_q;
		meas_d   = meas_q;
		side_b_d = side_b_q;
		pend_d   = pend_q;
		cnt_d    = meas_q ? cnt_q + 11'h001 : cnt_q;
		if (meas_end) begin
			cnt_d = 11'h000;
			if (pend_q) begin
				// Finish the other side before leaving non-continuous mode
				side_b_d = !side_b_q;
				pend_d   = 1'b0;
			end else begin
				meas_d = 1'b0;
			end
		end
		if (init_q != INIT_DONE) begin
			// Wait for the select synchroniser to fill before picking the start state
			init_d = init_q + 2'h1;
			if (init_q == SYNC_FILL) begin
				state_d = sel ? ST1_NC_MEAS_HI : ST8_NC_MEAS_LO;
			end
		end else begin
			unique case (state_q)
				ST1_NC_MEAS_HI: begin
					// Select changes while busy keep the machine here, so sides still alternate
					if (!meas_q) begin
						state_d = ST2_PREP_A;
					end
				end
				ST2_PREP_A: begin
					if (!sel) begin
						state_d = ST3_INT_A;
					end
				end
				ST3_INT_A: begin
					if (sel) begin
						state_d  = ST4_INT_B_MEAS_A;
						meas_d   = 1'b1;
						side_b_d = 1'b0;
						cnt_d    = 11'h000;
					end
				end
				ST4_INT_B_MEAS_A: begin
					if (!sel) begin
						if (meas_q) begin
							state_d = ST1_NC_MEAS_HI;
							pend_d  = 1'b1;
						end else begin
							state_d  = ST5_INT_A_MEAS_B;
							meas_d   = 1'b1;
							side_b_d = 1'b1;
							cnt_d    = 11'h000;
						end
					end
				end
				ST5_INT_A_MEAS_B: begin
					if (sel) begin
						if (meas_q) begin
							state_d = ST8_NC_MEAS_LO;
							pend_d  = 1'b1;
						end else begin
							state_d  = ST4_INT_B_MEAS_A;
							meas_d   = 1'b1;
							side_b_d = 1'b0;
							cnt_d    = 11'h000;
						end
					end
				end
				ST6_INT_B: begin
					if (!sel) begin
						state_d  = ST5_INT_A_MEAS_B;
						meas_d   = 1'b1;
						side_b_d = 1'b1;
						cnt_d    = 11'h000;
					end
				end
				ST7_PREP_B: begin
					if (sel) begin
						state_d = ST6_INT_B;
					end
				end
				ST8_NC_MEAS_LO: begin
					if (!meas_q) begin
						state_d = ST7_PREP_B;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			state_q  <= ST8_NC_MEAS_LO;
			init_q   <= 2'h0;
			meas_q   <= 1'b0;
			side_b_q <= 1'b0;
			pend_q   <= 1'b0;
			cnt_q    <= 11'h000;
		end else begin
			state_q  <= state_d;
			init_q   <= init_d;
			meas_q   <= meas_d;
			side_b_q <= side_b_d;
			pend_q   <= pend_d;
			cnt_q    <= cnt_d;
		end
	end

	// Offset-binary coding with saturation at both ends
	iasr_words_type sat_code;
	generate
		for (genvar i = 0; i < NUM_CH; i++) begin : g_code
			logic signed [ANALOG_BITS:0] biased;
			assign biased = $signed({adc_value_in[i][ANALOG_BITS-1], adc_value_in[i]})
				+ $signed({3'b000, ZERO_CODE});
			assign sat_code[i] = biased[ANALOG_BITS] ? 20'h00000 :
				(biased > $signed({3'b000, FULL_CODE})) ? FULL_CODE : biased[WIDE_BITS-1:0];
		end
	endgenerate

	// Data-ready handshake
	logic ready_q, ready_d;
	logic ready_n_neg_q;

	always_comb begin
		ready_d = ready_q;
		if (sck_fall) begin
			ready_d = 1'b0;
		end
		if (ready_pulse) begin
			ready_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= ready_d;
		end
	end

	// Pin changes only on the falling system clock edge
	always_ff @(negedge core_clk_in) begin
		if (!nrst_in) begin
			ready_n_neg_q <= 1'b1;
		end else begin
			ready_n_neg_q <= !ready_q;
		end
	end

	assign data_ready_n_out = ready_n_neg_q;

	// Result is loaded at the same edge the ready flag sets, so a read never sees stale words
	iasr_serial_out u_serial_out (
		.core_clk_in (core_clk_in),
		.nrst_in     (nrst_in),
		.load_in     (ready_pulse),
		.wide_in     (pin_s2_q[3]),
		.words_in    (sat_code),
		.shift_in    (sck_fall),
		.chain_in    (pin_s2_q[2]),
		.serial_out  (serial_out)
	);

	// Status: integrating sides, grounding and measure phase
	iasr_status_type status_q, status_d;

	always_comb begin
		status_d             = '0;
		status_d.meas_active = meas_d;
		status_d.meas_side_b = side_b_d;
		// Integrator reset absorbs whatever of the cycle is left after the converter phases
		if (cnt_d < ADCONV_CYC) begin
			status_d.phase = PH_CONVERT;
		end else if (cnt_d < ADC_END_CYC) begin
			status_d.phase = PH_ADC_RESET;
		end else begin
			status_d.phase = PH_INT_RESET;
		end
		status_d.integ_a  = (state_d == ST3_INT_A) || (state_d == ST5_INT_A_MEAS_B);
		status_d.integ_b  = (state_d == ST4_INT_B_MEAS_A) || (state_d == ST6_INT_B);
		status_d.grounded = !status_d.integ_a && !status_d.integ_b;
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			status_q <= '0;
		end else begin
			status_q <= status_d;
		end
	end

	assign status_out = status_q;

	// Cycles since the last measure start, for checking the ready delay
	logic [CNT_W-1:0] since_start_q;
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			since_start_q <= 11'h000;
		// Second measure of a non-continuous pair restarts the count too
		end else if ($rose(meas_q) || (meas_q && $past(meas_end))) begin
			since_start_q <= 11'h001;
		end else if (since_start_q != 11'h7FF) begin
			since_start_q <= since_start_q + 11'h001;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);

	chk_start_state: assert property (init_q == SYNC_FILL |=> state_q == ($past(sel) ? ST1_NC_MEAS_HI : ST8_NC_MEAS_LO))
		else $error("wrong power-up state");
	chk_cont_toggle: assert property (init_q == INIT_DONE && state_q == ST4_INT_B_MEAS_A && !sel && !meas_q
		|=> state_q == ST5_INT_A_MEAS_B && meas_q && side_b_q)
		else $error("continuous toggle 4 to 5 missed");
	chk_ready_delay: assert property ($rose(ready_q) && meas_q && !$past(pend_q) |-> since_start_q == CMDR_CYC)
		else $error("data ready not at the continuous delay");
	chk_meas_bound: assert property (meas_q |-> cnt_q < meas_len)
		else $error("measure cycle overran");
	chk_meas_length: assert property (meas_end && !pend_q |=> !meas_q)
		else $error("measure cycle did not end");
	chk_enter_ncont: assert property (init_q == INIT_DONE && state_q == ST5_INT_A_MEAS_B && sel && meas_q
		|=> state_q == ST8_NC_MEAS_LO && status_q.grounded)
		else $error("non-continuous entry missed");
	chk_ncont_from_four: assert property (init_q == INIT_DONE && state_q == ST4_INT_B_MEAS_A && !sel && meas_q
		|=> state_q == ST1_NC_MEAS_HI && status_q.grounded)
		else $error("non-continuous entry from side B integration missed");
	chk_leave_ncont: assert property (init_q == INIT_DONE && state_q == ST2_PREP_A && !sel |=> state_q == ST3_INT_A)
		else $error("first integration on side A not started");
	chk_prep_alt: assert property (init_q == INIT_DONE && state_q == ST7_PREP_B && sel |=> state_q == ST6_INT_B)
		else $error("preparation did not hand over to side B");
	chk_level_hold: assert property (init_q == INIT_DONE && state_q == ST3_INT_A && !sel |=> state_q == ST3_INT_A)
		else $error("state moved without select level change");
	chk_ready_release: assert property (ready_q && sck_fall && !ready_pulse |=> !ready_q ##1 data_ready_n_out)
		else $error("data ready not released by shift clock fall");
	chk_zero_offset: assert property (adc_value_in[0] == '0 |-> sat_code[0] == ZERO_CODE)
		else $error("zero input not at offset code");

	cov_cont_cycle: cover property (state_q == ST4_INT_B_MEAS_A ##[1:1000] state_q == ST5_INT_A_MEAS_B);
	cov_ncont_entry: cover property (state_q == ST4_INT_B_MEAS_A ##1 state_q == ST1_NC_MEAS_HI);
	cov_readout: cover property (ready_q ##1 sck_fall);

endmodule // iasr_sequencer

// ==== verification/iasr_host_model.sv ====
// Host controller model driving integrate select, shift clock and chain data
`timescale 1ns/1ps
module iasr_host_model (
	input  wire logic data_ready_n_in,
	input  wire logic serial_in,
	output logic      integrate_select_out,
	output logic      shift_clock_out,
	output logic      chain_out
);
	initial begin
		integrate_select_out = 1'b0;
		shift_clock_out = 1'b0;
		chain_out = 1'b0;
	end

	// Caller keeps the integration period and the quiet margins around it
	task automatic toggle_select();
		shift_clock_out = 1'b0;
		integrate_select_out = ~integrate_select_out;
	endtask

	// Shift clock rests low outside frames; 400 ns high, 400 ns low
	task automatic read_frame(input int nbits, input logic [7:0] pat,
		output logic [647:0] bits, output logic [1:0] ready_seen);
		bits = '0;
		ready_seen = 2'h0;
		// Odd offset keeps the shift clock off the system clock phase
		#37;
		for (int i = 0; i < nbits; i++) begin
			chain_out = pat[i[2:0]];
			shift_clock_out = 1'b1;
			#400;
			bits[i] = serial_in;
			if (i < 2)
				ready_seen[i] = data_ready_n_in;
			shift_clock_out = 1'b0;
			#400;
		end
		// Upstream hold time over, line no longer meaningful
		chain_out = ~chain_out;
	endtask
endmodule // iasr_host_model

// ==== verification/tb.sv ====
// Self-checking bench of the integrate/measure sequencer and serial readout
`timescale 1ns/1ps
module tb;
	import iasr_pkg::*;
	logic                core_clk_in;
	logic                nrst_in;
	logic                word_width_select_in;
	logic                high_speed_in;
	iasr_analog_bus_type adc_value_in;
	logic                integrate_select_in;
	logic                shift_clock_in;
	logic                chain_in;
	logic                data_ready_n_out;
	logic                serial_out;
	iasr_status_type     status_out;
	int                  bad_count;
	int                  n_tests;
	int                  meas_run;
	int                  meas_len;
	logic                prev_a;
	logic                have_prev;
	logic                fall_clk;
	logic [671:0]        exp_bits;
	logic [671:0]        got_bits;
	logic [1:0]          rdy;
	logic [7:0]          pat;

	iasr_sequencer dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .integrate_select_in(integrate_select_in),
		.shift_clock_in(shift_clock_in), .chain_in(chain_in), .word_width_select_in(word_width_select_in),
		.high_speed_in(high_speed_in), .adc_value_in(adc_value_in), .data_ready_n_out(data_ready_n_out),
		.serial_out(serial_out), .status_out(status_out));
	iasr_host_model host (.data_ready_n_in(data_ready_n_out), .serial_in(serial_out),
		.integrate_select_out(integrate_select_in), .shift_clock_out(shift_clock_in), .chain_out(chain_in));

	always #50 core_clk_in = ~core_clk_in;

	// Length of the latest measure cycle, seen at status
	always @(posedge core_clk_in) begin
		if (status_out.meas_active === 1'b1) begin
			meas_run <= meas_run + 1;
		end else begin
			if (meas_run != 0)
				meas_len <= meas_run;
			meas_run <= 0;
		end
	end

	always @(negedge data_ready_n_out) fall_clk = core_clk_in;

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic cmp_range(input int got, input int lo, input int hi);
		n_tests++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("wrong value at %0t: got %0h expected %0h to %0h", $time, got, lo, hi);
		end
	endtask

	function automatic logic [19:0] code_of(input logic signed [21:0] v);
		logic signed [23:0] s;
		s = v;
		s = s + 24'sh001000;
		if (s < 0)
			return 20'h00000;
		if (s > 24'sh0FFFFF)
			return 20'hFFFFF;
		return s[19:0];
	endfunction

	// Own words msb first, then the chain bits
	function automatic logic [671:0] expect_frame(input logic wide, input logic [7:0] p);
		logic [671:0] f;
		logic [19:0]  c;
		int           n;
		f = '0;
		n = 0;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			c = code_of(adc_value_in[ch]);
			for (int b = 19; b >= (wide ? 0 : TRUNC_BITS); b--) begin
				f[n] = c[b];
				n++;
			end
		end
		for (int k = 0; k < 8; k++) begin
			f[n + k] = p[k];
		end
		return f;
	endfunction

	// Integration sides must swap at every integration
	task automatic note_side();
		if (have_prev)
			cmp({31'h0, status_out.integ_a}, {31'h0, ~prev_a});
		prev_a = status_out.integ_a;
		have_prev = 1'b1;
	endtask

	task automatic run_period(input logic wide, input logic hs);
		int n;
		if (data_ready_n_out === 1'b0) begin
			host.read_frame(1, 8'h00, got_bits[647:0], rdy);
			@(negedge core_clk_in);
		end
		word_width_select_in = wide;
		high_speed_in = hs;
		pat = 8'($urandom);
		for (int ch = 0; ch < NUM_CH; ch++) begin
			adc_value_in[ch] = 22'($urandom);
		end
		adc_value_in[5:0] = {22'h3FEFFF, 22'h3FF000, 22'h0FF000, 22'h0FEFFF, 22'h00000F, 22'h000000};
		repeat (150) @(negedge core_clk_in);
		host.toggle_select();
		n = 0;
		while (data_ready_n_out !== 1'b0 && n < 3000) begin
			@(negedge core_clk_in);
			#1;
			n++;
		end
		cmp_range(n, CMDR_CYC + 1, CMDR_CYC + 7);
		if (n == 3000)
			close_out();
		cmp({31'h0, fall_clk}, 32'h0);
		cmp({31'h0, status_out.grounded}, 32'h0);
		note_side();
		cmp({29'h0, status_out.meas_active, status_out.phase}, {29'h0, 1'b1, PH_ADC_RESET});
		cmp({31'h0, status_out.meas_side_b ^ status_out.integ_a}, 32'h0);
		exp_bits = expect_frame(wide, pat);
		got_bits = '0;
		host.read_frame((wide ? SR_WIDE : SR_NARROW) + 8, pat, got_bits[647:0], rdy);
		cmp({30'h0, rdy}, 32'h2);
		for (int k = 0; k < 21; k++) begin
			cmp(got_bits[k * 32 +: 32], exp_bits[k * 32 +: 32]);
		end
		cmp_range(meas_len, (hs ? MRAZ_HS_CYC : MRAZ_LP_CYC) - 2, (hs ? MRAZ_HS_CYC : MRAZ_LP_CYC) + 2);
		@(negedge core_clk_in);
		repeat (400) @(negedge core_clk_in);
		$display("period done wide %0d fast %0d", wide, hs);
	endtask

	initial begin
		core_clk_in = 1'b0;
		nrst_in = 1'b0;
		word_width_select_in = 1'b1;
		high_speed_in = 1'b0;
		adc_value_in = '0;
		bad_count = 0;
		n_tests = 0;
		meas_run = 0;
		meas_len = 0;
		have_prev = 1'b0;
		prev_a = 1'b0;
		fall_clk = 1'b0;
		void'($urandom(32'h886EDE38));
		repeat (20) @(negedge core_clk_in);
		cmp({23'h0, data_ready_n_out, serial_out, status_out}, 32'h100); // Values held in reset
		nrst_in = 1'b1;
		repeat (10) @(negedge core_clk_in);
		cmp({31'h0, status_out.grounded}, 32'h1);
		repeat (3000) @(negedge core_clk_in);
		host.toggle_select();
		repeat (3000) @(negedge core_clk_in);
		note_side();
		$display("start-up done");
		run_period(1'b1, 1'b0);
		run_period(1'b0, 1'b1);
		for (int i = 0; i < 3; i++) begin
			run_period(1'($urandom), 1'($urandom));
		end
		// Integration ends while the other side still measures
		host.toggle_select();
		repeat (800) @(negedge core_clk_in);
		note_side();
		host.toggle_select();
		repeat (100) @(negedge core_clk_in);
		cmp({31'h0, status_out.grounded}, 32'h1);
		repeat (4000) @(negedge core_clk_in);
		note_side();
		cmp({31'h0, status_out.grounded}, 32'h0);
		host.toggle_select();
		repeat (3000) @(negedge core_clk_in);
		note_side();
		cmp({31'h0, status_out.grounded}, 32'h0);
		$display("early end done");
		run_period(1'b1, 1'b1);
		// Other direction: side A integration cut short while side B measures
		for (int i = 0; i < 2; i++) begin
			host.toggle_select();
			repeat (i == 0 ? 2000 : 800) @(negedge core_clk_in);
			note_side();
		end
		host.toggle_select();
		repeat (100) @(negedge core_clk_in);
		cmp({31'h0, status_out.grounded}, 32'h1);
		repeat (4000) @(negedge core_clk_in);
		note_side();
		cmp({31'h0, status_out.grounded}, 32'h0);
		$display("second early end done");
		close_out();
	end
endmodule // tb
